// ==== hdl/write_guard_cpu.sv ====
// cpu-side sequencer driving the guard interface
`timescale 1ns/1ps
`default_nettype none
module write_guard_cpu
  import write_guard_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  guard_bus_if.cpu         bus,
  input  wire logic [3:0]  sw_addr,
  input  wire logic [7:0]  sw_wdata,
  input  wire logic        sw_wr,
  input  wire logic        sw_rd,
  output logic      [7:0]  sw_rdata,
  output logic             irq
);
  typedef enum {IDLE, CMD, PROT, PLAIN, RD, RDWAIT, RDDATA, NOPS} state_e;
  state_e      state;
  logic [7:0]  tgt_addr;
  logic [7:0]  tgt_data;
  logic [7:0]  go;
  logic [7:0]  rd_result;
  logic [2:0]  nop_cnt;
  logic [1:0]  irq_status;
  logic [1:0]  irq_mask;
  logic [7:0]  swreg;
  logic        done_ev;
  logic        busy;

  assign busy    = state != IDLE;
  assign done_ev = (state == NOPS && nop_cnt == 3'(NOP_COUNT - 1)) || state == RDDATA;

  // software setup registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tgt_addr <= 8'h00;
      tgt_data <= 8'h00;
      go       <= 8'h00;
      irq_mask <= 2'h0;
      swreg    <= 8'h00;
    end else if (sw_wr) begin
      if (sw_addr == CTL_ADDR) tgt_addr <= sw_wdata;
      if (sw_addr == CTL_DATA) tgt_data <= sw_wdata;
      if (sw_addr == CTL_GO && !busy) go <= sw_wdata;
      if (sw_addr == CTL_IRQ_MASK) irq_mask <= sw_wdata[1:0];
      if (sw_addr == CTL_SWREG) swreg <= sw_wdata;
    end
  end

  // sequencer; command and protected store adjacent, same data
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state       <= IDLE;
      nop_cnt     <= 3'h0;
      rd_result   <= 8'h00;
      bus.wr      <= 1'b0;
      bus.rd      <= 1'b0;
      bus.addr    <= '0;
      bus.wdata   <= '0;
      bus.op      <= OP_STORE;
      bus.bit_sel <= 3'h0;
    end else begin
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
      unique case (state)
        IDLE: if (sw_wr && sw_addr == CTL_GO) begin
          unique case (sw_wdata[GO_KIND_LO +: 2])
            KIND_PROTECTED: state <= CMD;
            KIND_WRITE:     state <= PLAIN;
            default:        state <= RD;
          endcase
        end
        CMD: begin
          bus.wr    <= 1'b1;
          bus.addr  <= ADDR_PROT_CMD;
          bus.wdata <= tgt_data;
          bus.op    <= OP_STORE;
          state     <= PROT;
        end
        PROT, PLAIN: begin
          bus.wr      <= 1'b1;
          bus.addr    <= tgt_addr;
          bus.wdata   <= tgt_data;
          bus.op      <= bus_op_e'(go[GO_OP_LO +: 2]);
          bus.bit_sel <= go[GO_BIT_LO +: 3];
          nop_cnt     <= 3'h0;
          state       <= NOPS;
        end
        RD: begin
          bus.rd   <= 1'b1;
          bus.addr <= tgt_addr;
          state    <= RDWAIT;
        end
        RDWAIT: begin
          // device samples the strobe on this edge, data follows one cycle later
          state <= RDDATA;
        end
        RDDATA: begin
          rd_result <= bus.rdata;
          state     <= IDLE;
        end
        NOPS: begin
          // five idle cycles after the write
          nop_cnt <= nop_cnt + 3'h1;
          if (nop_cnt == 3'(NOP_COUNT - 1)) state <= IDLE;
        end
      endcase
    end
  end

  // sticky status, set beats write-one clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == IRQ_DONE && done_ev) || (i == IRQ_ERR && bus.wr && bus.addr == ADDR_SYS_STATUS))
          irq_status[i] <= 1'b1;
        else if (sw_wr && sw_addr == CTL_IRQ_STATUS && sw_wdata[i])
          irq_status[i] <= 1'b0;
      end
    end
  end

  // level interrupt
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) irq <= 1'b0;
    else        irq <= |(irq_status & irq_mask);
  end

  // read port, data one cycle after strobe
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sw_rdata <= 8'h00;
    end else if (sw_rd) begin
      unique case (sw_addr)
        CTL_ADDR:       sw_rdata <= tgt_addr;
        CTL_DATA:       sw_rdata <= tgt_data;
        CTL_GO:         sw_rdata <= go;
        CTL_STATUS:     sw_rdata <= {6'h00, bus.irq_hold, busy};
        CTL_RDATA:      sw_rdata <= rd_result;
        CTL_IRQ_STATUS: sw_rdata <= {6'h00, irq_status};
        CTL_IRQ_MASK:   sw_rdata <= {6'h00, irq_mask};
        CTL_SWREG:      sw_rdata <= swreg;
        default:        sw_rdata <= 8'h00;
      endcase
    end
  end
endmodule : write_guard_cpu
`default_nettype wire

// ==== hdl/write_guard_pkg.sv ====
// shared constants for the special register write guard
package write_guard_pkg;
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 8;
  // peripheral register addresses on the guard interface
  localparam logic [7:0]  ADDR_PROT_CMD   = 8'h00;
  localparam logic [7:0]  ADDR_POWER_SAVE = 8'h01;
  localparam logic [7:0]  ADDR_CLOCK_CTRL = 8'h02;
  localparam logic [7:0]  ADDR_WATCHDOG   = 8'h03;
  localparam logic [7:0]  ADDR_SYS_STATUS = 8'h04;
  localparam logic [7:0]  ADDR_PLAIN_REG  = 8'h05;
  // reset values
  localparam logic [7:0]  RST_POWER_SAVE  = 8'h00;
  localparam logic [7:0]  RST_CLOCK_CTRL  = 8'h00;
  localparam logic [7:0]  RST_WATCHDOG    = 8'h00;
  localparam logic [7:0]  RST_PLAIN_REG   = 8'h00;
  localparam logic [7:0]  CMD_READ_VALUE  = 8'h00;
  localparam int          PROT_ERR_BIT    = 0;
  localparam int          LOW_POWER_BIT   = 1;
  // bit operation codes
  typedef enum logic [1:0] {OP_STORE, OP_SET, OP_CLEAR, OP_INVERT} bus_op_e;
  // controller software port offsets
  localparam logic [3:0]  CTL_ADDR        = 4'h0;
  localparam logic [3:0]  CTL_DATA        = 4'h1;
  localparam logic [3:0]  CTL_GO          = 4'h2;
  localparam logic [3:0]  CTL_STATUS      = 4'h3;
  localparam logic [3:0]  CTL_RDATA       = 4'h4;
  localparam logic [3:0]  CTL_IRQ_STATUS  = 4'h5;
  localparam logic [3:0]  CTL_IRQ_MASK    = 4'h6;
  localparam logic [3:0]  CTL_SWREG       = 4'h7;
  // go register fields
  localparam int          GO_KIND_LO      = 0;
  localparam int          GO_OP_LO        = 2;
  localparam int          GO_BIT_LO       = 4;
  localparam logic [1:0]  KIND_READ       = 2'h0;
  localparam logic [1:0]  KIND_WRITE      = 2'h1;
  localparam logic [1:0]  KIND_PROTECTED  = 2'h2;
  localparam int          NOP_COUNT       = 5;
  localparam int          IRQ_DONE        = 0;
  localparam int          IRQ_ERR         = 1;
endpackage : write_guard_pkg

// ==== hdl/guard_bus_if.sv ====
// cpu-to-guard peripheral access interface
`timescale 1ns/1ps
`default_nettype none
interface guard_bus_if;
  import write_guard_pkg::*;
  logic                wr;      // one-cycle write strobe
  logic                rd;      // one-cycle read strobe
  logic [ADDR_W-1:0]   addr;
  logic [DATA_W-1:0]   wdata;
  bus_op_e             op;      // store or single-bit operation
  logic [2:0]          bit_sel;
  logic [DATA_W-1:0]   rdata;   // valid the cycle after rd
  logic                irq_hold; // interrupt acknowledge blocked

  modport device (input wr, rd, addr, wdata, op, bit_sel, output rdata, irq_hold);
  modport cpu    (output wr, rd, addr, wdata, op, bit_sel, input rdata, irq_hold);
endinterface : guard_bus_if
`default_nettype wire

// ==== hdl/bit_op_merge.sv ====
// applies a store or single-bit operation to a register value
`timescale 1ns/1ps
`default_nettype none
module bit_op_merge
  import write_guard_pkg::*;
(
  input  wire logic [DATA_W-1:0] old_value,
  input  wire logic [DATA_W-1:0] wdata,
  input  var  bus_op_e           op,
  input  wire logic [2:0]        bit_sel,
  output logic      [DATA_W-1:0] new_value
);
  // bit mask selects the one bit a bit operation touches
  logic [DATA_W-1:0] mask;
  always_comb begin
    mask      = '0;
    mask[bit_sel] = 1'b1;
    unique case (op)
      OP_STORE:  new_value = wdata;
      OP_SET:    new_value = old_value | mask;
      OP_CLEAR:  new_value = old_value & ~mask;
      OP_INVERT: new_value = old_value ^ mask;
    endcase
  end
endmodule : bit_op_merge
`default_nettype wire

// ==== hdl/write_guard_device.sv ====
// special register write guard, device end
//
// Operation
// - guard power save, clock, watchdog registers
// - cpu writes command then protected register
// - only first write after command counts
// - stores and bit operations both honoured
// - cpu runs five nops after write
// - five nops after low-power entry
// - protected registers read without unlock
// - no interrupt acknowledge on command store
// - command and protected stores back-to-back
// - command data ignored by device
// - command byte wide, reads return fixed filler
// - illegal sequence store flags error
// - protected write without command sets error
// - unprotected write after command sets error
// - writing zero clears error, wins
// - reads keep unlock for power, clock
`timescale 1ns/1ps
`default_nettype none
module write_guard_device
  import write_guard_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst_n,
  guard_bus_if.device            bus,
  output logic [DATA_W-1:0]      power_save,
  output logic [DATA_W-1:0]      clock_ctrl,
  output logic [DATA_W-1:0]      watchdog_mode,
  output logic                   protection_error_flag
);
  // guarded slots, in the order of the three register outputs
  localparam int                           SLOTS      = 3;
  localparam int                           SLOT_POWER = 0;
  localparam int                           SLOT_CLOCK = 1;
  localparam int                           SLOT_WATCH = 2;
  localparam logic [SLOTS-1:0][ADDR_W-1:0] SLOT_ADDR  = {ADDR_WATCHDOG, ADDR_CLOCK_CTRL, ADDR_POWER_SAVE};
  localparam logic [SLOTS-1:0][DATA_W-1:0] SLOT_RESET = {RST_WATCHDOG, RST_CLOCK_CTRL, RST_POWER_SAVE};

  logic              unlocked;
  logic [DATA_W-1:0] plain_reg;
  logic [DATA_W-1:0] cur_value;
  logic [DATA_W-1:0] merged;
  logic [DATA_W-1:0] status_word;
  logic [DATA_W-1:0] read_value;
  logic [DATA_W-1:0] slot_value [SLOTS];
  wire  logic [SLOTS-1:0] slot_hit;
  logic              is_cmd;
  logic              is_prot;
  logic              is_status;
  logic              is_plain;
  logic              wr_cmd_store;
  logic              rd_drops_unlock;
  logic              wr_unlocked_ok;
  logic              err_locked;
  logic              err_unguarded;
  logic              err_zero_write;

  // address decode of the current strobe
  assign is_cmd    = bus.addr == ADDR_PROT_CMD;
  assign is_status = bus.addr == ADDR_SYS_STATUS;
  assign is_plain  = bus.addr == ADDR_PLAIN_REG;
  assign is_prot   = |slot_hit;

  // system status byte, flag in its own bit, the rest reads zero
  always_comb begin
    status_word               = '0;
    status_word[PROT_ERR_BIT] = protection_error_flag;
  end

  // old value of the addressed register, for bit operations
  always_comb begin
    unique case (bus.addr)
      ADDR_POWER_SAVE: cur_value = power_save;
      ADDR_CLOCK_CTRL: cur_value = clock_ctrl;
      ADDR_WATCHDOG:   cur_value = watchdog_mode;
      ADDR_SYS_STATUS: cur_value = status_word;
      ADDR_PLAIN_REG:  cur_value = plain_reg;
      default:         cur_value = '0;
    endcase
  end

  bit_op_merge bit_op_merge_inst (
    .old_value (cur_value),
    .wdata     (bus.wdata),
    .op        (bus.op),
    .bit_sel   (bus.bit_sel),
    .new_value (merged)
  );

  // events that move the one-shot unlock
  assign wr_cmd_store    = bus.wr && is_cmd && bus.op == OP_STORE; // whole bytes only
  assign rd_drops_unlock = bus.rd && bus.addr == ADDR_WATCHDOG;    // power, clock reads exempt
  assign wr_unlocked_ok  = bus.wr && is_prot && unlocked;

  assign err_locked      = bus.wr && is_prot && !unlocked;
  assign err_unguarded   = bus.wr && !is_prot && unlocked;
  assign err_zero_write  = bus.wr && is_status && !merged[PROT_ERR_BIT];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      unlocked <= 1'b0;
    end else if (bus.wr) begin
      // any write spends the unlock, only a command store re-arms it
      unlocked <= wr_cmd_store;
    end else if (rd_drops_unlock) begin
      unlocked <= 1'b0;
    end
  end

  for (genvar g = 0; g < SLOTS; g++) begin : g_slot
    assign slot_hit[g] = bus.addr == SLOT_ADDR[g];
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        slot_value[g] <= SLOT_RESET[g];
      end else if (wr_unlocked_ok && slot_hit[g]) begin
        slot_value[g] <= merged;
      end
    end
  end

  // outputs taken straight from the slot flip-flops
  assign power_save    = slot_value[SLOT_POWER];
  assign clock_ctrl    = slot_value[SLOT_CLOCK];
  assign watchdog_mode = slot_value[SLOT_WATCH];

  // an ordinary unguarded register, a legal target for the error case
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      plain_reg <= RST_PLAIN_REG;
    end else if (bus.wr && is_plain) begin
      plain_reg <= merged;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      protection_error_flag <= 1'b0;
    end else if (err_zero_write) begin
      protection_error_flag <= 1'b0;
    end else if (err_locked) begin
      protection_error_flag <= 1'b1;
    end else if (err_unguarded) begin
      protection_error_flag <= 1'b1;
    end
  end

  // command reads fixed filler, it holds nothing readable
  always_comb begin
    if (is_cmd) begin
      read_value = CMD_READ_VALUE;
    end else begin
      read_value = cur_value;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bus.rdata <= '0;
    end else if (bus.rd) begin
      bus.rdata <= read_value;
    end
  end

  // block interrupt acknowledge after command store
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bus.irq_hold <= 1'b0;
    end else begin
      bus.irq_hold <= bus.wr && is_cmd;
    end
  end
endmodule : write_guard_device
`default_nettype wire

// ==== sim/write_guard_chk.sv ====
// concurrent checks on the guard interface
`timescale 1ns/1ps
`default_nettype none
module write_guard_chk
  import write_guard_pkg::*;
(
  input wire logic              clock,
  input wire logic              rst_n,
  input wire logic              wr,
  input wire logic              rd,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input var  bus_op_e           op,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic              irq_hold,
  input wire logic [DATA_W-1:0] power_save,
  input wire logic [DATA_W-1:0] watchdog_mode,
  input wire logic              protection_error_flag
);
  logic armed;
  logic prot;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // one of the three guarded addresses
  assign prot = addr inside {ADDR_POWER_SAVE, ADDR_CLOCK_CTRL, ADDR_WATCHDOG};
  // unlock as seen on the wire; a watchdog read also drops it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) armed <= 1'b0;
    else if (wr) armed <= (addr == ADDR_PROT_CMD) && (op == OP_STORE);
    else if (rd && addr == ADDR_WATCHDOG) armed <= 1'b0;
  end
  sequence s_cmd; wr && addr == ADDR_PROT_CMD && op == OP_STORE; endsequence
  sequence s_wd_store; wr && addr == ADDR_WATCHDOG && op == OP_STORE; endsequence
  property p_hold; s_cmd |=> irq_hold; endproperty
  a_hold: assert property (p_hold) else $error("interrupt hold missing after command");
  property p_unlock; s_cmd ##1 s_wd_store |=> watchdog_mode == $past(wdata); endproperty
  a_unlock: assert property (p_unlock) else $error("unlocked store not taken");
  property p_locked; wr && !armed && prot |=> protection_error_flag; endproperty
  a_locked: assert property (p_locked) else $error("locked write left no error");
  property p_keep; wr && !armed && addr == ADDR_POWER_SAVE |=> $stable(power_save); endproperty
  a_keep: assert property (p_keep) else $error("locked write changed register");
  property p_unprot;
    wr && armed && !prot && !(addr == ADDR_SYS_STATUS && (op != OP_STORE || !wdata[PROT_ERR_BIT]))
      |=> protection_error_flag;
  endproperty
  a_unprot: assert property (p_unprot) else $error("unguarded target left no error");
  property p_clear;
    wr && addr == ADDR_SYS_STATUS && op == OP_STORE && !wdata[PROT_ERR_BIT] |=> !protection_error_flag;
  endproperty
  a_clear: assert property (p_clear) else $error("error not cleared by zero");
  property p_sticky; protection_error_flag && !(wr && addr == ADDR_SYS_STATUS) |=> protection_error_flag; endproperty
  a_sticky: assert property (p_sticky) else $error("error flag dropped");
  property p_read; rd && addr == ADDR_POWER_SAVE |=> rdata == $past(power_save); endproperty
  a_read: assert property (p_read) else $error("direct read wrong");
  property p_cmd_read; rd && addr == ADDR_PROT_CMD |=> rdata == CMD_READ_VALUE; endproperty
  a_cmd_read: assert property (p_cmd_read) else $error("command read wrong");
endmodule : write_guard_chk
`default_nettype wire

// ==== sim/special_register_write_guard_bench.sv ====
// self-checking bench for both guard ends
`timescale 1ns/1ps
`default_nettype none
module special_register_write_guard_bench
  import write_guard_pkg::*;
;
  logic       clock = 1'b0;
  logic       rst_n;
  logic [3:0] sw_addr;
  logic [7:0] sw_wdata, sw_rdata, power_save, clock_ctrl, watchdog_mode, v;
  logic       sw_wr, sw_rd, irq, irq_a, protection_error_flag;
  int         fails = 0;
  int         check_count = 0;
  // 25 MHz system clock
  always #20 clock = ~clock;
  guard_bus_if guard_bus_if_inst ();
  write_guard_device write_guard_device_inst (.clock(clock), .rst_n(rst_n), .bus(guard_bus_if_inst),
    .power_save(power_save), .clock_ctrl(clock_ctrl), .watchdog_mode(watchdog_mode),
    .protection_error_flag(protection_error_flag));
  write_guard_cpu write_guard_cpu_inst (.clock(clock), .rst_n(rst_n), .bus(guard_bus_if_inst),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .irq(irq));
  write_guard_chk write_guard_chk_inst (.clock(clock), .rst_n(rst_n), .wr(guard_bus_if_inst.wr),
    .rd(guard_bus_if_inst.rd), .addr(guard_bus_if_inst.addr), .wdata(guard_bus_if_inst.wdata),
    .op(guard_bus_if_inst.op), .rdata(guard_bus_if_inst.rdata), .irq_hold(guard_bus_if_inst.irq_hold),
    .power_save(power_save), .watchdog_mode(watchdog_mode), .protection_error_flag(protection_error_flag));
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one-cycle strobes, launched just after the edge
  task automatic sw_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    sw_addr  <= a;
    sw_wdata <= d;
    sw_wr    <= 1'b1;
    @(posedge clock);
    sw_wr <= 1'b0;
  endtask : sw_write
  // data appears in the cycle after the strobe and holds until the next read
  task automatic sw_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    sw_addr <= a;
    sw_rd   <= 1'b1;
    @(posedge clock);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask : sw_read
  // load a bus request into the controller and wait, bounded, for it to finish
  task automatic access(input logic [7:0] a, input logic [7:0] d, input logic [1:0] k, input bus_op_e o,
                        input logic [2:0] b);
    logic [7:0] st;
    st = 8'h01;
    sw_write(CTL_ADDR, a);
    sw_write(CTL_DATA, d);
    sw_write(CTL_GO, {1'b0, b, o, k});
    for (int n = 0; n < 40 && st[0] !== 1'b0; n++) sw_read(CTL_STATUS, st);
    if (st[0] !== 1'b0) begin
      fails++;
      report_and_stop();
    end
  endtask : access
  initial begin
    rst_n    = 1'b0;
    sw_addr  = 4'h0;
    sw_wdata = 8'h00;
    sw_wr    = 1'b0;
    sw_rd    = 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    #1 check(power_save, RST_POWER_SAVE);
    check(clock_ctrl, RST_CLOCK_CTRL);
    check(watchdog_mode, RST_WATCHDOG);
    // plain store to a guarded register is dropped and flagged
    access(ADDR_POWER_SAVE, 8'hA5, KIND_WRITE, OP_STORE, 3'h0);
    check(power_save, RST_POWER_SAVE);
    check({7'h00, protection_error_flag}, 8'h01);
    // zero to status right after the command wins
    access(ADDR_SYS_STATUS, 8'h00, KIND_PROTECTED, OP_STORE, 3'h0);
    check({7'h00, protection_error_flag}, 8'h00);
    // every operation kind through the unlock
    access(ADDR_CLOCK_CTRL, 8'h00, KIND_PROTECTED, OP_SET, 3'h3);
    check(clock_ctrl, 8'h08);
    access(ADDR_CLOCK_CTRL, 8'h00, KIND_PROTECTED, OP_INVERT, 3'h0);
    check(clock_ctrl, 8'h09);
    access(ADDR_CLOCK_CTRL, 8'h00, KIND_PROTECTED, OP_CLEAR, 3'h3);
    check(clock_ctrl, 8'h01);
    access(ADDR_POWER_SAVE, 8'h5A, KIND_PROTECTED, OP_STORE, 3'h0);
    check(power_save, 8'h5A);
    access(ADDR_WATCHDOG, 8'h3C, KIND_PROTECTED, OP_STORE, 3'h0);
    check(watchdog_mode, 8'h3C);
    check({7'h00, protection_error_flag}, 8'h00);
    // unlocked write to an unguarded register is an error
    access(ADDR_PLAIN_REG, 8'h11, KIND_PROTECTED, OP_STORE, 3'h0);
    check({7'h00, protection_error_flag}, 8'h01);
    // reads need no unlock and keep the flag
    access(ADDR_POWER_SAVE, 8'h00, KIND_READ, OP_STORE, 3'h0);
    sw_read(CTL_RDATA, v);
    check(v, 8'h5A);
    access(ADDR_PROT_CMD, 8'h00, KIND_READ, OP_STORE, 3'h0);
    sw_read(CTL_RDATA, v);
    check(v, CMD_READ_VALUE);
    check({7'h00, protection_error_flag}, 8'h01);
    // done event is sticky; mask polarity is tested by its effect only
    sw_read(CTL_IRQ_STATUS, v);
    check({7'h00, v[IRQ_DONE]}, 8'h01);
    sw_write(CTL_IRQ_MASK, 8'h00);
    repeat (2) @(posedge clock);
    #1 irq_a = irq;
    sw_write(CTL_IRQ_MASK, 8'h03);
    repeat (2) @(posedge clock);
    #1 check({7'h00, irq_a ^ irq}, 8'h01);
    sw_write(CTL_IRQ_STATUS, 8'hFF);
    repeat (2) @(posedge clock);
    #1 check({7'h00, irq}, 8'h00);
    // scratch survives a write to an unmapped offset
    sw_write(CTL_SWREG, 8'hC3);
    sw_write(4'hF, 8'h00);
    sw_read(CTL_SWREG, v);
    check(v, 8'hC3);
    // mid-run reset clears flag and registers
    rst_n <= 1'b0;
    @(posedge clock);
    rst_n <= 1'b1;
    #1 check({7'h00, protection_error_flag}, 8'h00);
    check(power_save, RST_POWER_SAVE);
    report_and_stop();
  end
endmodule : special_register_write_guard_bench
`default_nettype wire
